// *** logic/ddr_write_ecc_error_check.sv ***
// Write-side check qualification and error reporting for a protected
// memory range, with an AXI4-Lite register slave.
// Assumes one clock domain; the memory side accepts a write every cycle.
`timescale 1ns/1ps
`include "wr_check_defs.svh"

module ddr_write_ecc_error_check
  import wr_check_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire wr_req_t req,
  output logic req_ready,
  output logic mem_valid,
  output mem_wr_t mem,
  output logic resp_valid,
  output cpu_resp_t resp,
  output logic irq,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ========================================================================
  // Registers
  logic merge_en_q;
  logic raw_q;
  logic en_q;
  logic [31:0] base_q;
  logic [31:0] limit_q;
  logic cap_valid_q;
  logic [31:0] cap_addr_q;
  logic irq_q;

  // ========================================================================
  // Request qualification
  logic taken;
  logic in_range;
  logic flag_err;

  assign taken = req_valid && req_ready;

  write_qualifier u_qual (
    .req(req),
    .base(base_q),
    .limit(limit_q),
    .merge_en(merge_en_q),
    .in_range(in_range),
    .flag_err(flag_err)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= 1'b1;
    end
  end

  // Memory path: zero-enable writes are dropped so data and check bits hold
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_valid <= 1'b0;
      mem <= '0;
    end else begin
      mem_valid <= taken && (req.be != 8'h00);
      if (taken) begin
        mem.addr <= req.addr;
        mem.be <= req.be;
        mem.data <= req.data;
        mem.merge <= merge_en_q && in_range;
      end
    end
  end

  // Status back to the CPU on every accepted write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp <= '0;
    end else begin
      resp_valid <= taken;
      if (taken) begin
        resp.err <= flag_err;
        resp.code <= flag_err ? `STAT_DATA_ERR : `STAT_NONE;
      end
    end
  end

  // ========================================================================
  // AXI4-Lite write channel
  bus_state_t bstate_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] aw_ofs_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic wr_hit;

  assign do_write = (bstate_q == BS_IDLE) && aw_got_q && w_got_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_ofs_q <= 8'h00;
      wdata_q <= `WORD_ZERO;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_got_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_ofs_q <= s_axi_awaddr[7:0];
      end else if (do_write) begin
        aw_got_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_got_q <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    if (aw_ofs_q == `OFS_CTRL) begin
      wr_hit = 1'b1;
    end else if (aw_ofs_q == `OFS_RAW || aw_ofs_q == `OFS_EN_SET) begin
      wr_hit = 1'b1;
    end else if (aw_ofs_q == `OFS_EN_CLR || aw_ofs_q == `OFS_BASE) begin
      wr_hit = 1'b1;
    end else if (aw_ofs_q == `OFS_LIMIT || aw_ofs_q == `OFS_CAP) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bstate_q <= BS_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else begin
      case (bstate_q)
        BS_IDLE: begin
          if (do_write) begin
            bstate_q <= BS_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
          end
        end
        BS_RESP: begin
          if (s_axi_bready) begin
            bstate_q <= BS_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          bstate_q <= BS_IDLE;
        end
      endcase
    end
  end

  // Strobes decoded per byte lane for full-word registers
  function automatic logic [31:0] merge_word(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic wr_ctrl;
  logic wr_raw_clr;
  logic wr_en_set;
  logic wr_en_clr;
  logic wr_cap_clr;

  assign wr_ctrl = do_write && aw_ofs_q == `OFS_CTRL && wstrb_q[0];
  assign wr_raw_clr = do_write && aw_ofs_q == `OFS_RAW && wstrb_q[0] && wdata_q[`ERR_BIT];
  assign wr_en_set = do_write && aw_ofs_q == `OFS_EN_SET && wstrb_q[0] && wdata_q[`ERR_BIT];
  assign wr_en_clr = do_write && aw_ofs_q == `OFS_EN_CLR && wstrb_q[0] && wdata_q[`ERR_BIT];
  assign wr_cap_clr = do_write && aw_ofs_q == `OFS_CAP && wstrb_q[3]
      && wdata_q[`CAP_VALID_BIT];

  // ========================================================================
  // Control and range registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      merge_en_q <= `CTRL_RST;
      base_q <= `BASE_RST;
      limit_q <= `LIMIT_RST;
    end else begin
      if (wr_ctrl) begin
        merge_en_q <= wdata_q[`MERGE_BIT];
      end
      if (do_write && aw_ofs_q == `OFS_BASE) begin
        base_q <= merge_word(base_q, wdata_q, wstrb_q);
      end
      if (do_write && aw_ofs_q == `OFS_LIMIT) begin
        limit_q <= merge_word(limit_q, wdata_q, wstrb_q);
      end
    end
  end

  // ========================================================================
  // Raw flag, enable and interrupt; a new error beats a clear in one cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      raw_q <= 1'b0;
    end else if (taken && flag_err) begin
      raw_q <= 1'b1;
    end else if (wr_raw_clr) begin
      raw_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
    end else if (wr_en_set) begin
      en_q <= 1'b1;
    end else if (wr_en_clr) begin
      en_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= raw_q && en_q;
    end
  end

  assign irq = irq_q;

  // First-error capture; later errors are lost until software clears it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cap_valid_q <= 1'b0;
      cap_addr_q <= `WORD_ZERO;
    end else if (taken && flag_err && (!cap_valid_q || wr_cap_clr)) begin
      cap_valid_q <= 1'b1;
      cap_addr_q <= req.addr;
    end else if (wr_cap_clr) begin
      cap_valid_q <= 1'b0;
    end
  end

  // ========================================================================
  // AXI4-Lite read channel
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `WORD_ZERO;
      s_axi_rresp <= `AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `AXI_OKAY;
        s_axi_rdata <= `WORD_ZERO;
        if (s_axi_araddr[7:0] == `OFS_CTRL) begin
          s_axi_rdata[`MERGE_BIT] <= merge_en_q;
        end else if (s_axi_araddr[7:0] == `OFS_RAW) begin
          s_axi_rdata[`ERR_BIT] <= raw_q;
        end else if (s_axi_araddr[7:0] == `OFS_EN_SET) begin
          s_axi_rdata[`ERR_BIT] <= en_q;
        end else if (s_axi_araddr[7:0] == `OFS_EN_CLR) begin
          s_axi_rdata[`ERR_BIT] <= en_q;
        end else if (s_axi_araddr[7:0] == `OFS_BASE) begin
          s_axi_rdata <= base_q;
        end else if (s_axi_araddr[7:0] == `OFS_LIMIT) begin
          s_axi_rdata <= limit_q;
        end else if (s_axi_araddr[7:0] == `OFS_CAP) begin
          s_axi_rdata[`CAP_VALID_BIT] <= cap_valid_q;
          s_axi_rdata[`CAP_CODE_MSB:0] <= cap_valid_q ? `STAT_DATA_ERR : `STAT_NONE;
        end else if (s_axi_araddr[7:0] == `OFS_CAP_ADDR) begin
          s_axi_rdata <= cap_addr_q;
        end else begin
          s_axi_rresp <= `AXI_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_err_taken;
    taken && flag_err;
  endsequence

  sequence s_err_reported;
    resp_valid && resp.err && resp.code == `STAT_DATA_ERR;
  endsequence

  property p_clean_write;
    taken && in_range && req.addr[2:0] == `QUANTA_ZERO && req.len[2:0] == `QUANTA_ZERO
        && req.len != 8'h00 |=> resp_valid && !resp.err;
  endproperty
  a_clean_write: assert property (p_clean_write) else $error("aligned write flagged");

  property p_bounding_write;
    taken && in_range && !merge_en_q && req.len == 8'h01 |=> raw_q && resp.err;
  endproperty
  a_bounding_write: assert property (p_bounding_write) else $error("bounding write missed");

  property p_raw_set;
    s_err_taken |=> raw_q;
  endproperty
  a_raw_set: assert property (p_raw_set) else $error("raw flag not set");

  property p_no_mem_write;
    taken && req.be == 8'h00 |=> !mem_valid;
  endproperty
  a_no_mem_write: assert property (p_no_mem_write) else $error("empty write reached memory");

  property p_irq_needs_enable;
    irq |-> $past(en_q) && $past(raw_q);
  endproperty
  a_irq_needs_enable: assert property (p_irq_needs_enable) else $error("irq without enable");

  property p_cpu_status;
    s_err_taken |=> s_err_reported;
  endproperty
  a_cpu_status: assert property (p_cpu_status) else $error("cpu error status missing");

  property p_merge_clean;
    taken && merge_en_q |=> resp_valid && !resp.err;
  endproperty
  a_merge_clean: assert property (p_merge_clean) else $error("merged write flagged");

  property p_first_kept;
    cap_valid_q && !wr_cap_clr |=> cap_valid_q && $stable(cap_addr_q);
  endproperty
  a_first_kept: assert property (p_first_kept) else $error("capture overwritten");

  property p_irq_follows;
    raw_q && en_q |=> irq ##1 (irq || !$past(raw_q) || !$past(en_q));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq not raised");

endmodule // ddr_write_ecc_error_check

// *** logic/wr_check_defs.svh ***
// Constants for the write-check block: register offsets, field positions,
// reset values and codes. Assumes inclusion by bare name from logic/.
`ifndef WR_CHECK_DEFS_SVH
`define WR_CHECK_DEFS_SVH

// ==========================================================================
// Register offsets (byte addresses, low 8 bits decoded)
`define OFS_CTRL 8'h00
`define OFS_RAW 8'h04
`define OFS_EN_SET 8'h08
`define OFS_EN_CLR 8'h0C
`define OFS_BASE 8'h10
`define OFS_LIMIT 8'h14
`define OFS_CAP 8'h18
`define OFS_CAP_ADDR 8'h1C

// ==========================================================================
// Field positions
`define MERGE_BIT 0
`define ERR_BIT 0
`define CAP_VALID_BIT 31
`define CAP_CODE_MSB 3

// ==========================================================================
// Reset values and codes
`define CTRL_RST 1'h0
`define BASE_RST 32'h8000_0000
`define LIMIT_RST 32'hFFFF_FFFF
`define STAT_DATA_ERR 4'h4
`define STAT_NONE 4'h0
`define QUANTA_ZERO 3'h0
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`define WORD_ZERO 32'h0000_0000

`endif

// *** logic/wr_check_pkg.sv ***
// Types shared by the write-check block. Assumes nothing of its surroundings.
package wr_check_pkg;

  // Write request from a cache controller or bus master
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] len;
    logic [7:0] be;
    logic [63:0] data;
  } wr_req_t;

  // Write passed on to the memory side
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] be;
    logic [63:0] data;
    logic merge;
  } mem_wr_t;

  // Status returned to the originating CPU
  typedef struct packed {
    logic err;
    logic [3:0] code;
  } cpu_resp_t;

  typedef enum logic [1:0] {
    BS_IDLE = 2'h0,
    BS_RESP = 2'h1
  } bus_state_t;

endpackage

// *** logic/write_qualifier.sv ***
// Alignment and quanta check of one write against the protected range.
// Assumes a request that is stable while it is being qualified.
`timescale 1ns/1ps
`include "wr_check_defs.svh"

module write_qualifier
  import wr_check_pkg::*;
(
  input wire wr_req_t req,
  input wire logic [31:0] base,
  input wire logic [31:0] limit,
  input wire logic merge_en,
  output logic in_range,
  output logic flag_err
);

  // Nonzero low bits mean the value is not a whole 64-bit quantum
  function automatic logic off_quanta(input logic [2:0] v);
    return v != `QUANTA_ZERO;
  endfunction

  logic misaligned;
  logic sub_quanta;

  always_comb begin
    in_range = (req.addr >= base) && (req.addr <= limit);
    misaligned = off_quanta(req.addr[2:0]);
    sub_quanta = off_quanta(req.len[2:0]) || (req.len == 8'h00);
    // Merge mode absorbs short and misaligned writes
    flag_err = in_range && (misaligned || sub_quanta) && !merge_en;
  end

endmodule // write_qualifier

// *** testbench/wb_requester.sv ***
// Cache-side requester model: one block writeback per start pulse.
// Assumes the block's request port and its one-cycle acceptance.
`timescale 1ns/1ps
module wb_requester
  import wr_check_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [31:0] line_addr,
  input wire logic [7:0] line_bytes,
  input wire logic req_ready,
  output logic req_valid,
  output wr_req_t req,
  output logic busy
);
  logic [7:0] offs_q;

  // ==========================================================================
  // Whole-line writeback, then the zero-enable bounding byte
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_valid <= 1'b0;
      req <= '0;
      offs_q <= 8'h00;
      busy <= 1'b0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      req_valid <= 1'b1;
      req <= '{addr: line_addr, len: 8'h08, be: 8'hFF, data: {32'h0000_0000, line_addr}};
      offs_q <= 8'h08;
    end else if (busy && req_valid && req_ready) begin
      if (offs_q < line_bytes) begin
        req <= '{addr: line_addr + offs_q, len: 8'h08, be: 8'hFF, data: ~req.data};
        offs_q <= offs_q + 8'h08;
      end else if (offs_q == line_bytes) begin
        // Last address of the line, one byte, no enables
        req <= '{addr: line_addr + line_bytes - 1, len: 8'h01, be: 8'h00, data: ~req.data};
        offs_q <= offs_q + 8'h01;
      end else begin
        // Released: payload keeps toggling so nothing reads a stale word
        req_valid <= 1'b0;
        busy <= 1'b0;
        req.data <= ~req.data;
      end
    end else if (!req_valid) begin
      req.data <= ~req.data;
    end
  end
endmodule // wb_requester

// *** testbench/ddr_write_ecc_error_check_tb_top.sv ***
// Self-checking bench: request table, register map, interrupt and writebacks.
// Assumes the block's package and the requester model on the request port.
`timescale 1ns/1ps
module ddr_write_ecc_error_check_tb_top;
  import wr_check_pkg::*;
  typedef struct {
    logic [31:0] addr; logic [7:0] len; logic [7:0] be; logic mrg; logic err;
  } row_t;
  logic clock = 0, rst_n = 0, tb_valid = 0, use_model = 0, start = 0;
  logic req_ready, req_valid, mem_valid, resp_valid, irq, m_valid, busy;
  wr_req_t tb_req = '0, m_req, req;
  mem_wr_t mem;
  cpu_resp_t resp;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d, lba = 0;
  logic [3:0] wstrb = 0;
  logic [7:0] lbb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int n_fail = 0, checks_done = 0, n_resp, n_err, n_mem;
  row_t rows[7] = '{
    '{32'h8000_0000, 8'h08, 8'hFF, 1'b0, 1'b0},
    '{32'h8000_0040, 8'h40, 8'hFF, 1'b0, 1'b0},
    '{32'h8000_0003, 8'h01, 8'h01, 1'b0, 1'b1},
    '{32'h8000_007F, 8'h01, 8'h00, 1'b0, 1'b1},
    '{32'h1000_0001, 8'h01, 8'h01, 1'b0, 1'b0},
    '{32'h8000_0100, 8'h00, 8'h00, 1'b0, 1'b1},
    '{32'h8000_0005, 8'h03, 8'h07, 1'b1, 1'b0}};

  always #10 clock = ~clock;
  assign req_valid = use_model ? m_valid : tb_valid;
  assign req = use_model ? m_req : tb_req;

  ddr_write_ecc_error_check uut (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .mem_valid(mem_valid), .mem(mem),
    .resp_valid(resp_valid), .resp(resp), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  wb_requester model (.clock(clock), .rst_n(rst_n), .start(start), .line_addr(lba),
    .line_bytes(lbb), .req_ready(req_ready), .req_valid(m_valid), .req(m_req), .busy(busy));

  // ==========================================================================
  // Shared tasks
  always @(posedge clock) begin
    if (resp_valid) n_resp++;
    if (resp_valid && resp.err) n_err++;
    if (mem_valid) n_mem++;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
    logic done;
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    // Waits as long as the slave needs; only the watchdog ends a hang
    while (!done) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        done = 1'b1;
        check(bresp, er);
      end
    end
    // Idle edge so a following call never re-raises bready in this time step
    @(posedge clock);
  endtask

  task automatic axi_rd(input logic [31:0] a, input logic [1:0] er, output logic [31:0] v);
    logic done;
    v = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        done = 1'b1;
        v = rdata;
        check(rresp, er);
      end
    end
    @(posedge clock);
  endtask

  task automatic send(input row_t r);
    tb_req <= '{addr: r.addr, len: r.len, be: r.be, data: 64'h1234_5678_9ABC_DEF0};
    tb_valid <= 1'b1;
    @(posedge clock);
    check(req_ready, 1);
    tb_valid <= 1'b0;
    @(posedge clock);
    check(resp_valid, 1);
    check(resp.err, r.err);
    check(resp.code, r.err ? 4'h4 : 4'h0);
    check(mem_valid, r.be != 0);
    if (r.be != 0) begin
      check({mem.addr, mem.be, 7'h00, mem.merge}, {r.addr, r.be, 7'h00, r.mrg});
      check(mem.data, 64'h1234_5678_9ABC_DEF0);
    end
  endtask

  task automatic writeback(input logic [31:0] a, input logic [7:0] lb, input int e_err);
    int n;
    n_resp = 0;
    n_err = 0;
    n_mem = 0;
    lba <= a;
    lbb <= lb;
    use_model <= 1'b1;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (busy && n < 300);
    repeat (2) @(posedge clock);
    use_model <= 1'b0;
    check(n_resp, lb / 8 + 1);
    check(n_mem, lb / 8);
    check(n_err, e_err);
    $display("Writeback of %0d bytes done", lb);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    axi_rd(32'h10, 2'h0, d);
    check(d, 32'h8000_0000);
    axi_rd(32'h14, 2'h0, d);
    check(d, 32'hFFFF_FFFF);
    axi_rd(32'h20, 2'h2, d);
    check(d, 0);
    axi_wr(32'h20, 32'h0000_0001, 2'h2);
    $display("Reset values done");
    foreach (rows[i]) begin
      axi_wr(32'h00, {31'h0, rows[i].mrg}, 2'h0);
      send(rows[i]);
    end
    $display("Request table done");
    check(irq, 0);
    axi_rd(32'h04, 2'h0, d);
    check(d, 1);
    axi_rd(32'h18, 2'h0, d);
    check(d, 32'h8000_0004);
    axi_rd(32'h1C, 2'h0, d);
    check(d, 32'h8000_0003);
    axi_wr(32'h08, 32'h0000_0001, 2'h0);
    check(irq, 1);
    axi_wr(32'h04, 32'h0000_0001, 2'h0);
    check(irq, 0);
    axi_wr(32'h18, 32'h8000_0000, 2'h0);
    axi_wr(32'h00, 32'h0000_0000, 2'h0);
    writeback(32'h8000_0000, 8'h80, 1);
    check(irq, 1);
    axi_rd(32'h1C, 2'h0, d);
    check(d, 32'h8000_007F);
    axi_wr(32'h14, 32'h8000_00FF, 2'h0);
    axi_rd(32'h14, 2'h0, d);
    check(d, 32'h8000_00FF);
    send('{32'h8000_0101, 8'h01, 8'h01, 1'b0, 1'b0});
    axi_wr(32'h14, 32'hFFFF_FFFF, 2'h0);
    $display("Range limit done");
    axi_wr(32'h0C, 32'h0000_0001, 2'h0);
    axi_wr(32'h04, 32'h0000_0001, 2'h0);
    axi_wr(32'h00, 32'h0000_0001, 2'h0);
    writeback(32'h8000_1000, 8'h40, 0);
    axi_rd(32'h04, 2'h0, d);
    check(d, 0);
    check(irq, 0);
    // Mid-run reset: merge mode and a held capture must both be wiped
    rst_n <= 1'b0;
    @(posedge clock);
    check(req_ready, 0);
    check(irq, 0);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    axi_rd(32'h00, 2'h0, d);
    check(d, 0);
    axi_rd(32'h18, 2'h0, d);
    check(d, 0);
    $display("Mid-run reset done");
    close_out();
  end

  // Bounded by roughly a hundred times the expected run length
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    close_out();
  end
endmodule // ddr_write_ecc_error_check_tb_top
